// ===== design/smp_pkg.sv
package smp_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets on the bus.
    localparam logic [7:0] OFF_ENABLE_TWO = 8'h00;
    localparam logic [7:0] OFF_STATUS_TWO = 8'h04;
    localparam logic [7:0] OFF_CONTROL = 8'h08;
    localparam logic [7:0] OFF_CLEAR_CMD = 8'h0c;
    localparam logic [7:0] OFF_LOG_STATUS = 8'h10;
    localparam logic [7:0] OFF_LOG_CLEAR = 8'h14;
    localparam logic [7:0] OFF_LOG_ENABLE = 8'h18;

    // Bit positions of event_enable_two and event_status_two; bits 0 to 2 are shared.
    localparam int BIT_ADDR_CHG = 0;
    localparam int BIT_REM_CHG = 1;
    localparam int BIT_LOK_CHG = 2;
    localparam int BIT_REM_STATE = 4;
    localparam int BIT_LOK_STATE = 5;
    localparam int BIT_XFER_IN = 4;
    localparam int BIT_XFER_OUT = 5;
    localparam int BIT_INT = 7;

    // Control register fields.
    localparam int BIT_STATIC_SEL = 0;
    localparam int BIT_FIFO_MODE = 1;

    // Reset values.
    localparam logic [7:0] RST_ENABLE_TWO = 8'h00;
    localparam logic [1:0] RST_CONTROL = 2'h0;
    localparam logic [2:0] RST_FLAGS = 3'h0;

    localparam int NUM_FLAGS = 3;

    // AHB transfer types and response.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

// ===== design/smp_status_mask_pair.sv
`timescale 1ns/1ps
// How it works
// - Status read clears event flags only while static status select is zero.
// - Flags follow their own conditions; mask bits gate interrupts, and bits 5 and 4 also pick transfer requests in FIFO mode.
// - An event arriving during a clearing status read is held and set after it.
// - Reset clears the whole mask register, all enables off.
// - An enabled status condition may raise the interrupt request.
// - Status bit 7 is the OR of all enabled status sources except the event log.
// - Status bits 6 and 3 have no meaning; they read zero here.
// - Status bits 5 and 4 show lockout and remote state.
// - FIFO mode with output enable turns data-out into a transfer request.
// - FIFO mode with input enable turns data-in into a transfer request.
// - Lockout change flag sets on lockout edges; clears on read or command.
// - Remote change flag sets on remote edges; clears on read or command.
// - Address change flag tracks speaker, listener, major edges unless only-modes.
module smp_status_mask_pair (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [smp_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [smp_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [smp_pkg::DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic lockout_state,
    input wire logic far_control_state,
    input wire logic addressed_as_speaker,
    input wire logic addressed_as_listener,
    input wire logic major_minor_select,
    input wire logic listen_only,
    input wire logic talk_only,
    input wire logic other_enabled_pending,
    input wire logic data_out_condition,
    input wire logic data_out_int_enable,
    input wire logic data_in_condition,
    input wire logic data_in_int_enable,
    output logic xfer_out_request,
    output logic xfer_in_request,
    output logic irq
);
    import smp_pkg::*;

    logic [7:0] enable_two_reg;
    logic [1:0] control_reg;
    logic [NUM_FLAGS-1:0] flags_reg;
    logic [NUM_FLAGS-1:0] held_reg;
    logic [NUM_FLAGS-1:0] log_reg;
    logic [NUM_FLAGS-1:0] log_en_reg;
    logic lok_prev_reg;
    logic rem_prev_reg;
    logic [2:0] address_status_reg_prev_reg;
    logic busy_reg;
    logic write_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] hrdata_reg;
    logic hreadyout_reg;
    logic xfer_out_reg;
    logic xfer_in_reg;
    logic irq_reg;
    logic hresp_reg;

    logic static_sel;
    logic fifo_mode;
    logic accept;
    logic status_read;
    logic clearing_read;
    logic [NUM_FLAGS-1:0] event_now;
    logic [NUM_FLAGS-1:0] clear_cmd;
    logic [NUM_FLAGS-1:0] log_clear;
    logic [2:0] address_status_reg_now;
    logic only_mode;
    logic do_to_xfer;
    logic di_to_xfer;
    logic int_pending;
    logic [7:0] status_two;
    logic [DATA_W-1:0] read_mux;
    logic [NUM_FLAGS-1:0] flags_next;
    logic [NUM_FLAGS-1:0] held_next;
    logic [NUM_FLAGS-1:0] log_next;
    logic wr_active;
    logic rd_active;
    logic wr_enable_two;
    logic wr_control;
    logic wr_clear_cmd;
    logic wr_log_clear;
    logic wr_log_enable;

    assign static_sel = control_reg[BIT_STATIC_SEL];
    assign fifo_mode = control_reg[BIT_FIFO_MODE];

    // Address phase is taken only when the bus is ready and a real transfer is on.
    assign accept = hsel && hready && (htrans == HTRANS_NONSEQ) && !busy_reg;

    // The status register read is in progress during the single wait cycle.
    assign status_read = busy_reg && !write_reg && (addr_reg == OFF_STATUS_TWO);
    assign clearing_read = status_read && !static_sel;

    assign address_status_reg_now = {major_minor_select, addressed_as_listener, addressed_as_speaker};
    assign only_mode = listen_only || talk_only;

    always_comb begin
        event_now = '0;
        event_now[BIT_LOK_CHG] = lockout_state != lok_prev_reg;
        event_now[BIT_REM_CHG] = far_control_state != rem_prev_reg;
        event_now[BIT_ADDR_CHG] = (address_status_reg_now != address_status_reg_prev_reg) && !only_mode;
    end

    // One strobe per write target keeps the address decode in a single place.
    assign wr_active = busy_reg && write_reg;
    assign rd_active = busy_reg && !write_reg;

    always_comb begin
        wr_enable_two = 1'b0;
        wr_control = 1'b0;
        wr_clear_cmd = 1'b0;
        wr_log_clear = 1'b0;
        wr_log_enable = 1'b0;
        if (wr_active) begin
            case (addr_reg)
                OFF_ENABLE_TWO: wr_enable_two = 1'b1;
                OFF_CONTROL: wr_control = 1'b1;
                OFF_CLEAR_CMD: wr_clear_cmd = 1'b1;
                OFF_LOG_CLEAR: wr_log_clear = 1'b1;
                OFF_LOG_ENABLE: wr_log_enable = 1'b1;
                default: wr_enable_two = 1'b0;
            endcase
        end
    end

    always_comb begin
        clear_cmd = '0;
        log_clear = '0;
        if (wr_clear_cmd) begin
            clear_cmd = hwdata[NUM_FLAGS-1:0];
        end
        if (wr_log_clear) begin
            log_clear = hwdata[NUM_FLAGS-1:0];
        end
    end

    // A FIFO-assisted transfer enable steals the data condition from the interrupt path.
    assign do_to_xfer = fifo_mode && enable_two_reg[BIT_XFER_OUT];
    assign di_to_xfer = fifo_mode && enable_two_reg[BIT_XFER_IN];

    // Global pending bit across all three status registers.
    always_comb begin
        int_pending = other_enabled_pending;
        if (data_out_condition && data_out_int_enable && !do_to_xfer) begin
            int_pending = 1'b1;
        end
        if (data_in_condition && data_in_int_enable && !di_to_xfer) begin
            int_pending = 1'b1;
        end
        if (|(flags_reg & enable_two_reg[NUM_FLAGS-1:0])) begin
            int_pending = 1'b1;
        end
    end

    always_comb begin
        status_two = 8'h00;
        status_two[BIT_INT] = int_pending;
        status_two[BIT_LOK_STATE] = lockout_state;
        status_two[BIT_REM_STATE] = far_control_state;
        status_two[NUM_FLAGS-1:0] = flags_reg;
    end

    // Write-only registers read back as zero.
    always_comb begin
        read_mux = '0;
        case (addr_reg)
            OFF_STATUS_TWO: read_mux[7:0] = status_two;
            OFF_CONTROL: read_mux[1:0] = control_reg;
            OFF_LOG_STATUS: read_mux[NUM_FLAGS-1:0] = log_reg;
            OFF_LOG_ENABLE: read_mux[NUM_FLAGS-1:0] = log_en_reg;
            default: read_mux = '0;
        endcase
    end

    // Bus slave: one wait cycle so that read data comes from a flip-flop.
    // The cost is a fixed two-cycle data phase, writes included.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_reg <= 1'b0;
        end else if (clk_en) begin
            if (accept) begin
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                busy_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            write_reg <= 1'b0;
            addr_reg <= '0;
        end else if (clk_en && accept) begin
            write_reg <= hwrite;
            addr_reg <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_reg <= 1'b1;
        end else if (clk_en) begin
            if (accept) begin
                hreadyout_reg <= 1'b0;
            end else if (busy_reg) begin
                hreadyout_reg <= 1'b1;
            end
        end
    end

    // The response never changes, yet it leaves through a flip-flop like every output.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_reg <= HRESP_OKAY;
        end else if (clk_en) begin
            hresp_reg <= HRESP_OKAY;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= '0;
        end else if (clk_en) begin
            if (rd_active) begin
                hrdata_reg <= read_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_two_reg <= RST_ENABLE_TWO;
        end else if (clk_en && wr_enable_two) begin
            enable_two_reg <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_reg <= RST_CONTROL;
        end else if (clk_en && wr_control) begin
            control_reg <= hwdata[1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            log_en_reg <= '0;
        end else if (clk_en && wr_log_enable) begin
            log_en_reg <= hwdata[NUM_FLAGS-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lok_prev_reg <= 1'b0;
            rem_prev_reg <= 1'b0;
            address_status_reg_prev_reg <= 3'h0;
        end else if (clk_en) begin
            lok_prev_reg <= lockout_state;
            rem_prev_reg <= far_control_state;
            address_status_reg_prev_reg <= address_status_reg_now;
        end
    end

    // Every change flag has the same set, hold and clear terms but for the only-mode kill of the address flag, so one loop builds them.
    // An edge seen during a clearing read waits in the hold bit for one cycle,
    // so the read returns the old value and the new event still appears after it.
    // Only one cycle of hold-off exists, which is enough since reads come two apart.
    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
        logic kill;
        assign kill = only_mode && (i == BIT_ADDR_CHG);
        assign held_next[i] = clearing_read && event_now[i] && !kill;
        assign flags_next[i] = (kill || clearing_read) ? 1'b0 :
            ((flags_reg[i] && !clear_cmd[i]) || event_now[i] || held_reg[i]);
        // Sticky event log; a new event wins over a clear in the same cycle.
        assign log_next[i] = (log_reg[i] && !log_clear[i]) || event_now[i];
    end

    // Flags follow their own conditions whatever the mask holds.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_reg <= RST_FLAGS;
            held_reg <= RST_FLAGS;
        end else if (clk_en) begin
            flags_reg <= flags_next;
            held_reg <= held_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            log_reg <= '0;
        end else if (clk_en) begin
            log_reg <= log_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xfer_out_reg <= 1'b0;
        end else if (clk_en) begin
            xfer_out_reg <= do_to_xfer && data_out_condition;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xfer_in_reg <= 1'b0;
        end else if (clk_en) begin
            xfer_in_reg <= di_to_xfer && data_in_condition;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_reg <= 1'b0;
        end else if (clk_en) begin
            irq_reg <= int_pending || (|(log_reg & log_en_reg));
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;
    assign xfer_out_request = xfer_out_reg;
    assign xfer_in_request = xfer_in_reg;
    assign irq = irq_reg;

endmodule

// ===== testbench/smp_fifo_model.sv
`timescale 1ns/1ps
// Stands in for the FIFO engine: it serves every transfer request at once and
// counts one move per cycle with either request high, so the bench can see that the requests reached it.
module smp_fifo_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic xfer_out_request,
    input wire logic xfer_in_request,
    output logic [7:0] moves
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            moves <= 8'h00;
        end else if (xfer_out_request || xfer_in_request) begin
            moves <= moves + 8'h01;
        end
    end
endmodule

// ===== testbench/smp_checker.sv
`timescale 1ns/1ps
module smp_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic data_out_condition,
    input wire logic data_in_condition,
    input wire logic other_enabled_pending,
    input wire logic xfer_out_request,
    input wire logic xfer_in_request,
    input wire logic irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_accept;
        hsel && hready && htrans == 2'h2 && hreadyout;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
    a_wait_one: assert property (s_accept |=> s_one_wait) else $error("bad wait state");
    a_idle_ready: assert property (hreadyout && !(hsel && htrans == 2'h2) |=> hreadyout)
        else $error("ready dropped with no transfer");
    a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved outside a read");
    a_xout_cond: assert property (!data_out_condition |=> !xfer_out_request)
        else $error("output request with no condition");
    a_xin_cond: assert property (!data_in_condition |=> !xfer_in_request)
        else $error("input request with no condition");
    a_irq_other: assert property (other_enabled_pending |=> irq)
        else $error("irq low with a pending source");
    a_reset_quiet: assert property ($rose(hresetn) |-> !xfer_out_request && !xfer_in_request)
        else $error("request active out of reset");
endmodule
bind smp_status_mask_pair smp_checker chk_i (.hclk, .hresetn, .hsel, .htrans, .hready,
    .hreadyout, .hresp, .hrdata, .data_out_condition, .data_in_condition,
    .other_enabled_pending, .xfer_out_request, .xfer_in_request, .irq);

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import smp_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp, xfer_out_request, xfer_in_request, irq;
    logic lockout_state = 0, far_control_state = 0, addressed_as_speaker = 0;
    logic listen_only = 0, major_minor_select = 0, other_enabled_pending = 0;
    logic data_out_condition = 0, data_out_int_enable = 0, data_in_condition = 0;
    logic addressed_as_listener = 0, talk_only = 0, data_in_int_enable = 0;
    logic [7:0] moves;
    int failures = 0, checks = 0;
    always #50 hclk = ~hclk;
    smp_status_mask_pair uut (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .lockout_state, .far_control_state, .addressed_as_speaker,
        .addressed_as_listener, .major_minor_select, .listen_only, .talk_only,
        .other_enabled_pending, .data_out_condition, .data_out_int_enable,
        .data_in_condition, .data_in_int_enable, .xfer_out_request,
        .xfer_in_request, .irq);
    smp_fifo_model fm (.hclk, .hresetn, .xfer_out_request, .xfer_in_request, .moves);
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // Bits 6 and 3 carry no meaning, so they are masked out of every status compare.
    task automatic st(input logic [7:0] e);
        bus(1'b0, OFF_STATUS_TWO, 32'h0);
        chk("status", {24'h0, e}, rd & 32'hffff_ffb7);
        chk("resp", 32'h0, {31'h0, hresp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic t_reset;
        st(8'h00);
        bus(1'b0, OFF_ENABLE_TWO, 32'h0);
        chk("enable", 32'h0, rd);
        bus(1'b0, 8'h1c, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test reset done");
    endtask
    task automatic t_lock;
        lockout_state <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        st(8'h24);
        st(8'h20);
        $display("test lock done");
    endtask
    task automatic t_static;
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_ENABLE_TWO, 32'h2);
        far_control_state <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("irq", 32'h1, {31'h0, irq});
        st(8'hb2);
        st(8'hb2);
        wr(OFF_CLEAR_CMD, 32'h2);
        repeat (2) @(posedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        st(8'h30);
        $display("test static done");
    endtask
    task automatic t_addr;
        wr(OFF_CONTROL, 32'h0);
        wr(OFF_ENABLE_TWO, 32'h1);
        listen_only <= 1'b1;
        addressed_as_speaker <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        st(8'h30);
        listen_only <= 1'b0;
        repeat (2) @(posedge hclk);
        major_minor_select <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("irq", 32'h1, {31'h0, irq});
        st(8'hb1);
        repeat (2) @(posedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        addressed_as_listener <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("irq", 32'h1, {31'h0, irq});
        talk_only <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        st(8'h30);
        talk_only <= 1'b0;
        $display("test addr done");
    endtask
    task automatic t_log;
        wr(OFF_LOG_CLEAR, 32'h7);
        lockout_state <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        bus(1'b0, OFF_LOG_STATUS, 32'h0);
        chk("log", 32'h4, rd & 32'h7);
        wr(OFF_LOG_ENABLE, 32'h4);
        repeat (2) @(posedge hclk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(OFF_LOG_CLEAR, 32'h4);
        repeat (2) @(posedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test log done");
    endtask
    task automatic t_xfer;
        wr(OFF_CONTROL, 32'h2);
        wr(OFF_ENABLE_TWO, 32'h30);
        data_out_condition <= 1'b1;
        data_out_int_enable <= 1'b1;
        data_in_int_enable <= 1'b1;
        data_in_condition <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("xfer_out", 32'h1, {31'h0, xfer_out_request});
        chk("xfer_in", 32'h1, {31'h0, xfer_in_request});
        chk("irq", 32'h0, {31'h0, irq});
        chk("moved", 32'h1, {31'h0, moves != 8'h00});
        wr(OFF_CONTROL, 32'h0);
        repeat (2) @(posedge hclk);
        chk("xfer_out", 32'h0, {31'h0, xfer_out_request});
        chk("xfer_in", 32'h0, {31'h0, xfer_in_request});
        chk("irq", 32'h1, {31'h0, irq});
        data_out_condition <= 1'b0;
        data_in_condition <= 1'b0;
        other_enabled_pending <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("irq", 32'h1, {31'h0, irq});
        other_enabled_pending <= 1'b0;
        $display("test xfer done");
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // The whole run needs some 140 cycles; about twenty times that means a hang.
    initial begin
        #300000;
        failures++;
        test_done;
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_lock;
        t_static;
        t_addr;
        t_log;
        t_xfer;
        test_done;
    end
endmodule
